// file: common/bstap_pkg.sv
package bstap_pkg;

    localparam int IR_W        = 8;
    localparam int BSR_W       = 113;
    localparam int ID_W        = 32;
    localparam int BYP_W       = 1;
    localparam int TLR_TMS_CNT = 5;

    // instruction codes
    localparam logic [IR_W-1:0] INS_EXTEST = 8'h00;
    localparam logic [IR_W-1:0] INS_IDCODE = 8'h21;
    localparam logic [IR_W-1:0] INS_SAMPLE = 8'h05;
    localparam logic [IR_W-1:0] INS_CLAMP  = 8'h07;
    localparam logic [IR_W-1:0] INS_HIGHZ  = 8'h03;
    localparam logic [IR_W-1:0] INS_BYPASS = 8'hff;

    // capture pattern of the instruction register, low two bits are 01
    localparam logic [IR_W-1:0] IR_CAPTURE = 8'h01;
    localparam logic [1:0]      IR_CAP_LSB = 2'h1;

    typedef enum logic [3:0] {
        ST_RESET,
        ST_IDLE,
        ST_SEL_DR,
        ST_CAP_DR,
        ST_SHIFT_DR,
        ST_EXIT1_DR,
        ST_PAUSE_DR,
        ST_EXIT2_DR,
        ST_UPD_DR,
        ST_SEL_IR,
        ST_CAP_IR,
        ST_SHIFT_IR,
        ST_EXIT1_IR,
        ST_PAUSE_IR,
        ST_EXIT2_IR,
        ST_UPD_IR
    } bstap_state_type;

endpackage : bstap_pkg

// file: hdl/bstap_scan_reg.sv
`timescale 1ns/100ps
module bstap_scan_reg #(
    parameter int               WIDTH   = 8,
    parameter logic [WIDTH-1:0] UPD_RST = {WIDTH{1'b0}}
) (
    input  logic             tck,
    input  logic             testRst,
    input  logic             captureEn,
    input  logic             shiftEn,
    input  logic             updateEn,
    input  logic [WIDTH-1:0] captureVal,
    input  logic             tdi,
    output logic [WIDTH-1:0] shiftVal,
    output logic [WIDTH-1:0] updateVal
);

    logic [WIDTH-1:0] shift_ff;
    logic [WIDTH-1:0] upd_ff;
    logic [WIDTH-1:0] nxt_shift;

    // serial data enters at the msb and leaves from the lsb
    generate
        if (WIDTH == 1) begin : g_one
            assign nxt_shift = tdi;
        end else begin : g_many
            assign nxt_shift = {tdi, shift_ff[WIDTH-1:1]};
        end
    endgenerate

    always_ff @(posedge tck) begin
        if (testRst) begin
            shift_ff <= {WIDTH{1'b0}};
        end else if (captureEn) begin
            shift_ff <= captureVal;
        end else if (shiftEn) begin
            shift_ff <= nxt_shift;
        end
    end

    always_ff @(posedge tck) begin
        if (testRst) begin
            upd_ff <= UPD_RST;
        end else if (updateEn) begin
            upd_ff <= shift_ff;
        end
    end

    assign shiftVal  = shift_ff;
    assign updateVal = upd_ff;

endmodule : bstap_scan_reg

// file: hdl/bstap_top.sv
`timescale 1ns/100ps
module bstap_top #(
    parameter logic [bstap_pkg::ID_W-1:0] ID_CODE = 32'h0a5a_5001 // arbitrary value
) (
    input  logic                        ref_clk,
    input  logic                        rst,
    input  logic                        tck,
    input  logic                        tms,
    input  logic                        tdi,
    output logic                        tdo,
    output logic                        tdoOe,
    input  logic [bstap_pkg::BSR_W-1:0] pinIn,
    output logic [bstap_pkg::BSR_W-1:0] bsrDrive,
    output logic                        drivePinsFromScan,
    output logic                        forceHighz
);

    // ---------------- test clock domain ----------------
    logic                        rstMeta_ff;
    logic                        rstTck_ff;
    logic                        tapAlive_ff;
    logic [bstap_pkg::BSR_W-1:0] pinMeta_ff;
    logic [bstap_pkg::BSR_W-1:0] pinSync_ff;
    bstap_pkg::bstap_state_type  state_ff;
    bstap_pkg::bstap_state_type  nxt_state;
    logic                        tdo_ff;
    logic                        tdoEn_ff;
    logic                        updToggle_ff;
    logic                        modeDrive_ff;
    logic                        modeHighz_ff;

    // the core reset is foreign to the test clock, so it is synchronised first
    always_ff @(posedge tck) begin
        rstMeta_ff <= rst;
        rstTck_ff  <= rstMeta_ff;
    end

    // pins belong to the core, two stages before capture
    always_ff @(posedge tck) begin
        pinMeta_ff <= pinIn;
        pinSync_ff <= pinMeta_ff;
    end

    // controller state graph; tms decides every step
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            bstap_pkg::ST_RESET:
                nxt_state = tms ? bstap_pkg::ST_RESET : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_IDLE:
                nxt_state = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_SEL_DR:
                nxt_state = tms ? bstap_pkg::ST_SEL_IR : bstap_pkg::ST_CAP_DR;
            bstap_pkg::ST_CAP_DR:
                nxt_state = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_SHIFT_DR:
                nxt_state = tms ? bstap_pkg::ST_EXIT1_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_EXIT1_DR:
                nxt_state = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_PAUSE_DR;
            bstap_pkg::ST_PAUSE_DR:
                nxt_state = tms ? bstap_pkg::ST_EXIT2_DR : bstap_pkg::ST_PAUSE_DR;
            bstap_pkg::ST_EXIT2_DR:
                nxt_state = tms ? bstap_pkg::ST_UPD_DR : bstap_pkg::ST_SHIFT_DR;
            bstap_pkg::ST_UPD_DR:
                nxt_state = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
            bstap_pkg::ST_SEL_IR:
                nxt_state = tms ? bstap_pkg::ST_RESET : bstap_pkg::ST_CAP_IR;
            bstap_pkg::ST_CAP_IR:
                nxt_state = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_SHIFT_IR:
                nxt_state = tms ? bstap_pkg::ST_EXIT1_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_EXIT1_IR:
                nxt_state = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_PAUSE_IR;
            bstap_pkg::ST_PAUSE_IR:
                nxt_state = tms ? bstap_pkg::ST_EXIT2_IR : bstap_pkg::ST_PAUSE_IR;
            bstap_pkg::ST_EXIT2_IR:
                nxt_state = tms ? bstap_pkg::ST_UPD_IR : bstap_pkg::ST_SHIFT_IR;
            bstap_pkg::ST_UPD_IR:
                nxt_state = tms ? bstap_pkg::ST_SEL_DR : bstap_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge tck) begin
        if (rstTck_ff) begin
            state_ff <= bstap_pkg::ST_RESET;
        end else begin
            state_ff <= nxt_state;
        end
    end

    wire inReset  = (state_ff == bstap_pkg::ST_RESET);
    wire capDr    = (state_ff == bstap_pkg::ST_CAP_DR);
    wire shiftDr  = (state_ff == bstap_pkg::ST_SHIFT_DR);
    wire updDr    = (state_ff == bstap_pkg::ST_UPD_DR);
    wire capIr    = (state_ff == bstap_pkg::ST_CAP_IR);
    wire shiftIr  = (state_ff == bstap_pkg::ST_SHIFT_IR);
    wire updIr    = (state_ff == bstap_pkg::ST_UPD_IR);
    // reset state keeps all test logic inactive and only touches scan state
    wire testRst  = rstTck_ff | inReset;

    // instruction register
    logic [bstap_pkg::IR_W-1:0] irShift;
    logic [bstap_pkg::IR_W-1:0] irActive;

    bstap_scan_reg #(
        .WIDTH   (bstap_pkg::IR_W),
        .UPD_RST (bstap_pkg::INS_IDCODE)
    ) u_ir (
        .tck        (tck),
        .testRst    (testRst),
        .captureEn  (capIr),
        .shiftEn    (shiftIr),
        .updateEn   (updIr),
        .captureVal (bstap_pkg::IR_CAPTURE),
        .tdi        (tdi),
        .shiftVal   (irShift),
        .updateVal  (irActive)
    );

    // exactly one data register per instruction; unknown codes fall to bypass
    wire selBsr    = (irActive == bstap_pkg::INS_EXTEST) |
                     (irActive == bstap_pkg::INS_SAMPLE);
    wire selId     = (irActive == bstap_pkg::INS_IDCODE);
    wire selBypass = ~selBsr & ~selId;
    wire isExtest  = (irActive == bstap_pkg::INS_EXTEST);
    wire newBypass = updIr & (irShift == bstap_pkg::INS_BYPASS);

    // boundary scan register
    logic [bstap_pkg::BSR_W-1:0] bsrShift;
    logic [bstap_pkg::BSR_W-1:0] bsrUpd;

    bstap_scan_reg #(
        .WIDTH   (bstap_pkg::BSR_W)
    ) u_bsr (
        .tck        (tck),
        .testRst    (testRst),
        .captureEn  (capDr & selBsr),
        .shiftEn    (shiftDr & selBsr),
        .updateEn   (updDr & selBsr),
        .captureVal (pinSync_ff),
        .tdi        (tdi),
        .shiftVal   (bsrShift),
        .updateVal  (bsrUpd)
    );

    // identification register, hardwired capture value
    logic [bstap_pkg::ID_W-1:0] idShift;

    bstap_scan_reg #(
        .WIDTH   (bstap_pkg::ID_W)
    ) u_id (
        .tck        (tck),
        .testRst    (testRst),
        .captureEn  (capDr & selId),
        .shiftEn    (shiftDr & selId),
        .updateEn   (1'b0),
        .captureVal (ID_CODE),
        .tdi        (tdi),
        .shiftVal   (idShift),
        .updateVal  ()
    );

    // bypass cell, cleared on capture and when the bypass code takes effect
    logic [bstap_pkg::BYP_W-1:0] bypShift;

    bstap_scan_reg #(
        .WIDTH   (bstap_pkg::BYP_W)
    ) u_byp (
        .tck        (tck),
        .testRst    (testRst),
        .captureEn  ((capDr & selBypass) | newBypass),
        .shiftEn    (shiftDr & selBypass),
        .updateEn   (1'b0),
        .captureVal (1'b0),
        .tdi        (tdi),
        .shiftVal   (bypShift),
        .updateVal  ()
    );

    wire drBit  = selBsr ? bsrShift[0] : (selId ? idShift[0] : bypShift[0]);
    wire outBit = shiftIr ? irShift[0] : drBit;

    // launch on the falling edge, half a period of hold for the next device
    always_ff @(negedge tck) begin
        if (rstTck_ff) begin
            tdo_ff   <= 1'b0;
            tdoEn_ff <= 1'b0;
        end else begin
            tdo_ff   <= outBit;
            tdoEn_ff <= shiftIr | shiftDr;
        end
    end

    always_ff @(posedge tck) begin
        if (rstTck_ff) begin
            tapAlive_ff  <= 1'b0;
            updToggle_ff <= 1'b0;
            modeDrive_ff <= 1'b0;
            modeHighz_ff <= 1'b0;
        end else begin
            tapAlive_ff  <= 1'b1;
            modeDrive_ff <= isExtest | (irActive == bstap_pkg::INS_CLAMP);
            modeHighz_ff <= (irActive == bstap_pkg::INS_HIGHZ);
            if (updDr & isExtest) begin
                updToggle_ff <= ~updToggle_ff;
            end
        end
    end

    // ---------------- core clock domain ----------------
    logic       aliveMeta_ff;
    logic       aliveSync_ff;
    logic       driveMeta_ff;
    logic       driveSync_ff;
    logic       hizMeta_ff;
    logic       hizSync_ff;
    logic [2:0] togSync_ff;
    logic [bstap_pkg::BSR_W-1:0] bsrDrive_ff;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            aliveMeta_ff <= 1'b0;
            aliveSync_ff <= 1'b0;
            driveMeta_ff <= 1'b0;
            driveSync_ff <= 1'b0;
            hizMeta_ff   <= 1'b0;
            hizSync_ff   <= 1'b0;
            togSync_ff   <= 3'h0;
        end else begin
            aliveMeta_ff <= tapAlive_ff;
            aliveSync_ff <= aliveMeta_ff;
            driveMeta_ff <= modeDrive_ff;
            driveSync_ff <= driveMeta_ff;
            hizMeta_ff   <= modeHighz_ff;
            hizSync_ff   <= hizMeta_ff;
            togSync_ff   <= {togSync_ff[1:0], updToggle_ff};
        end
    end

    // the latched word is stable for several test clocks after each toggle
    wire updSeen = togSync_ff[2] ^ togSync_ff[1];

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            bsrDrive_ff <= {bstap_pkg::BSR_W{1'b0}};
        end else if (updSeen) begin
            bsrDrive_ff <= bsrUpd;
        end
    end

    assign bsrDrive          = bsrDrive_ff;
    assign drivePinsFromScan = driveSync_ff;
    assign forceHighz        = hizSync_ff;
    // the core-side gate keeps the pin high impedance before any test clock
    assign tdoOe             = tdoEn_ff & aliveSync_ff;
    assign tdo               = tdo_ff;

    // ---------------- checks ----------------
    a_five_tms_reset: assert property (@(posedge tck) disable iff (rstTck_ff)
        tms [*5] |=> (state_ff == bstap_pkg::ST_RESET))
        else $error("five high mode-select edges did not reach reset");

    a_idle_hold: assert property (@(posedge tck) disable iff (rstTck_ff)
        (state_ff == bstap_pkg::ST_IDLE) && !tms |=> (state_ff == bstap_pkg::ST_IDLE))
        else $error("idle state left while mode-select low");

    a_tdo_enable_state: assert property (@(posedge tck) disable iff (rstTck_ff)
        $past(!rstTck_ff) |-> (tdoEn_ff == (shiftIr | shiftDr)))
        else $error("serial output enable outside shift states");

    a_capture_ir_pattern: assert property (@(posedge tck) disable iff (rstTck_ff)
        capIr |=> (irShift[1:0] == bstap_pkg::IR_CAP_LSB))
        else $error("capture-ir pattern wrong");

    a_ir_reset_idcode: assert property (@(posedge tck) disable iff (rstTck_ff)
        inReset |=> (irActive == bstap_pkg::INS_IDCODE))
        else $error("reset state did not restore identification code");

    a_ir_update_only: assert property (@(posedge tck) disable iff (rstTck_ff)
        !updIr && !inReset |=> $stable(irActive))
        else $error("instruction changed outside update-ir");

    a_bsr_update_only: assert property (@(posedge tck) disable iff (rstTck_ff)
        !updDr && !inReset |=> $stable(bsrUpd))
        else $error("boundary outputs changed outside update-dr");

    a_select_dr_hold: assert property (@(posedge tck) disable iff (rstTck_ff)
        (state_ff == bstap_pkg::ST_SEL_DR) |=> $stable(bsrShift) && $stable(idShift))
        else $error("data register changed in select-dr");

    a_shift_dr_msb: assert property (@(posedge tck) disable iff (rstTck_ff)
        shiftDr && selBsr |=> (bsrShift[bstap_pkg::BSR_W-1] == $past(tdi)))
        else $error("boundary shift did not take serial input at msb");

    a_bypass_clear: assert property (@(posedge tck) disable iff (rstTck_ff)
        (capDr && selBypass) || newBypass |=> (bypShift == 1'b0))
        else $error("bypass cell not cleared");

    a_id_capture: assert property (@(posedge tck) disable iff (rstTck_ff)
        capDr && selId |=> (idShift == ID_CODE))
        else $error("identification value not captured");

    a_pause_dr_hold: assert property (@(posedge tck) disable iff (rstTck_ff)
        (state_ff == bstap_pkg::ST_PAUSE_DR) |=>
        $stable(bsrShift) && $stable(idShift) && $stable(bypShift))
        else $error("data register moved in pause-dr");

    a_tdo_bsr_lsb: assert property (@(posedge tck) disable iff (rstTck_ff)
        shiftDr && selBsr |-> (tdo == bsrShift[0]))
        else $error("serial output not from boundary register lsb");

    a_tdo_ir_lsb: assert property (@(posedge tck) disable iff (rstTck_ff)
        shiftIr |-> (tdo == irShift[0]))
        else $error("serial output not from instruction register lsb");

    a_bypass_shift: assert property (@(posedge tck) disable iff (rstTck_ff)
        shiftDr && selBypass |=> (bypShift[0] == $past(tdi)))
        else $error("bypass cell did not take serial input");

    a_extest_toggle: assert property (@(posedge tck) disable iff (rstTck_ff)
        updDr && isExtest |=> (updToggle_ff != $past(updToggle_ff)))
        else $error("update under external test not passed to core side");

endmodule : bstap_top

// file: test/bstap_host.sv
`timescale 1ns/100ps
module bstap_host (
    output logic tck,
    output logic tms,
    output logic tdi
);
    // unused inputs sit at the pulled-up level, so the port idles in reset
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b1;
    end


    // levels change while tck is low and hold across the rising edge
    task automatic step(input logic m, input logic d);
        tms = m;
        tdi = d;
        #16 tck = 1'b1;
        #16 tck = 1'b0;
    endtask : step

    // scan from idle; one pause after bit pauseAt; upd low leaves it parked in pause
    task automatic scan(input bit ir, input int n, input logic [112:0] din,
                        input int pauseAt, input bit upd);
        step(1'b1, 1'b1);
        if (ir)
            step(1'b1, 1'b1);
        step(1'b0, 1'b1);
        step(1'b0, 1'b1);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1 || i == pauseAt, din[i]);
            if (i == pauseAt && i != n - 1) begin
                step(1'b0, 1'b1);
                step(1'b0, 1'b1);
                step(1'b1, 1'b1);
                step(1'b0, 1'b1);
            end
        end
        if (upd)
            step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : scan

    // leave pause through exit2 and update, back to idle
    task automatic resume();
        step(1'b1, 1'b1);
        step(1'b1, 1'b1);
        step(1'b0, 1'b1);
    endtask : resume
endmodule : bstap_host

// file: test/bstap_top_bench.sv
`timescale 1ns/100ps
module bstap_top_bench;
    localparam logic [31:0] ID_VAL = 32'h3c69_e0a5; // arbitrary value

    logic                        refClk;
    logic                        rst;
    logic                        tck;
    logic                        tms;
    logic                        tdi;
    logic                        tdo;
    logic                        tdoOe;
    logic [bstap_pkg::BSR_W-1:0] pinIn;
    logic [bstap_pkg::BSR_W-1:0] bsrDrive;
    logic                        drivePins;
    logic                        forceHighz;
    logic [1:0]                  expQ[$];
    logic [1:0]                  e;
    logic [112:0]                d;
    logic [112:0]                q;
    logic [7:0]                  codes[4];
    int                          error_cnt = 0;
    int                          n_checks = 0;
    int                          cyc = 0;

    initial refClk = 1'b0;
    always #5 refClk = ~refClk;

    bstap_top #(.ID_CODE(ID_VAL)) dut_u (
        .ref_clk          (refClk),
        .rst              (rst),
        .tck              (tck),
        .tms              (tms),
        .tdi              (tdi),
        .tdo              (tdo),
        .tdoOe            (tdoOe),
        .pinIn            (pinIn),
        .bsrDrive         (bsrDrive),
        .drivePinsFromScan(drivePins),
        .forceHighz       (forceHighz)
    );

    bstap_host host_u (.tck(tck), .tms(tms), .tdi(tdi));

    task automatic summarize();
        if (error_cnt == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    task automatic cmp(input string nm, input logic [112:0] ex, input logic [112:0] got);
        n_checks++;
        if (got !== ex) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, ex, got);
        end
    endtask : cmp

    task automatic note(input int n, input logic [112:0] v, input logic [112:0] care);
        for (int i = 0; i < n; i++)
            expQ.push_back({care[i], v[i]});
    endtask : note

    function automatic logic [112:0] rnd();
        logic [127:0] r;
        r = {$urandom(), $urandom(), $urandom(), $urandom()};
        return r[112:0];
    endfunction : rnd

    task automatic loadIr(input logic [7:0] code);
        note(8, {111'h0, bstap_pkg::IR_CAP_LSB}, 113'h3);
        host_u.scan(1'b1, 8, {105'h0, code}, -1, 1'b1);
        // mode flags follow the new instruction only at the next test clock
        host_u.step(1'b0, 1'b1);
        repeat (12) @(posedge refClk);
    endtask : loadIr

    // pins settle for two idle tck edges so the capture flops see them
    task automatic drScan(input logic [112:0] pins, input logic [112:0] din, input bit upd);
        @(posedge refClk);
        pinIn <= pins;
        host_u.step(1'b0, 1'b1);
        host_u.step(1'b0, 1'b1);
        note(113, pins, '1);
        host_u.scan(1'b0, 113, din, -1, upd);
        repeat (12) @(posedge refClk);
    endtask : drScan

    // every serial bit with its care flag set is judged at the rising edge that takes it
    always @(posedge tck) begin
        if (tdoOe === 1'b1 && expQ.size() > 0) begin
            e = expQ.pop_front();
            if (e[1])
                cmp("tdo", e[0], tdo);
        end else begin
            cmp("tdoOe", 1'b0, tdoOe);
        end
    end

    always @(posedge refClk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        rst = 1'b1;
        pinIn = '0;
        codes = '{bstap_pkg::INS_CLAMP, bstap_pkg::INS_HIGHZ, bstap_pkg::INS_BYPASS, 8'h5a};
        void'($urandom(32'h86ba193f));
        // the tck side only sees reset while tck runs, so hold it long enough for both
        fork
            begin
                repeat (8) @(posedge refClk);
                rst <= 1'b0;
            end
            repeat (5) host_u.step(1'b1, 1'b1);
        join
        repeat (3) @(posedge refClk);
        cmp("bsrDrive", '0, bsrDrive);
        cmp("drivePins", 1'b0, drivePins);
        cmp("forceHighz", 1'b0, forceHighz);
        repeat (5) host_u.step(1'b1, 1'b1);
        repeat (3) host_u.step(1'b0, 1'b1);
        note(32, ID_VAL, '1);
        host_u.scan(1'b0, 32, rnd(), 13, 1'b1);
        loadIr(bstap_pkg::INS_SAMPLE);
        drScan(rnd(), rnd(), 1'b1);
        cmp("bsrDrive", '0, bsrDrive);
        loadIr(bstap_pkg::INS_EXTEST);
        cmp("drivePins", 1'b1, drivePins);
        for (int k = 0; k < 2; k++) begin
            d = rnd();
            drScan(rnd(), d, k == 0);
            if (k == 1) begin
                cmp("bsrDrive", q, bsrDrive);
                host_u.resume();
                repeat (12) @(posedge refClk);
            end
            cmp("bsrDrive", d, bsrDrive);
            q = d;
        end
        foreach (codes[j]) begin
            loadIr(codes[j]);
            cmp("drivePins", codes[j] == bstap_pkg::INS_CLAMP, drivePins);
            cmp("forceHighz", codes[j] == bstap_pkg::INS_HIGHZ, forceHighz);
            d = rnd();
            note(9, {d[111:0], 1'b0}, {{112{1'b1}}, codes[j] == bstap_pkg::INS_BYPASS});
            host_u.scan(1'b0, 9, d, -1, 1'b1);
        end
        // abandon a shift half way; five high edges must still reach reset
        host_u.step(1'b1, 1'b1);
        host_u.step(1'b0, 1'b1);
        host_u.step(1'b0, 1'b1);
        note(1, '0, '0);
        repeat (5) host_u.step(1'b1, 1'b1);
        host_u.step(1'b0, 1'b1);
        note(32, ID_VAL, '1);
        host_u.scan(1'b0, 32, rnd(), -1, 1'b1);
        cmp("pending", '0, expQ.size());
        summarize();
    end
endmodule : bstap_top_bench
